// ### bench/crf_core_properties.sv
`timescale 1ns/100ps
`default_nettype none
module crf_core_chk (
	// System
	input wire logic        clock,
	input wire logic        rst,
	// Register bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [5:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Memory and interrupts
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [15:0] mem_adr,
	input wire logic        mem_ack,
	input wire logic [7:0]  irq_req,
	input wire logic        irq_taken,
	input wire logic [2:0]  irq_num
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic first_q;
	always_ff @(posedge clock or posedge rst)
		if (rst)
			first_q <= 1'b1;
		else
			first_q <= 1'b0;
	property p_boot;
		first_q |=> mem_req && !mem_we && mem_adr == 16'hFFFE;
	endproperty
	a_boot: assert property (p_boot) else $error("boot fetch wrong");
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ack too long");
	property p_idle;
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000;
	endproperty
	a_idle: assert property (p_idle) else $error("data without ack");
	property p_flags;
		wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i[5:2]) == crf_pkg::REG_FLAGS
			|-> wb_dat_o[6:5] == 2'b11;
	endproperty
	a_flags: assert property (p_flags) else $error("fixed flag bits");
	property p_prio;
		irq_taken |-> ($past(irq_req) & (8'h01 << irq_num)) != 8'h00
			&& ($past(irq_req) & ((8'h01 << irq_num) - 8'h01)) == 8'h00;
	endproperty
	a_prio: assert property (p_prio) else $error("wrong request taken");
	property p_irq_once;
		irq_taken |=> !irq_taken [*2];
	endproperty
	a_irq_once: assert property (p_irq_once) else $error("repeat entry");
	property p_mem_hold;
		mem_req && !mem_ack |=> mem_req && $stable(mem_adr) && $stable(mem_we);
	endproperty
	a_mem_hold: assert property (p_mem_hold) else $error("memory request moved");
	cover property (irq_taken);
	cover property (mem_req && mem_we && mem_ack);
	cover property (wb_ack_o && !$past(wb_we_i));
endmodule : crf_core_chk
bind crf_core crf_core_chk u_crf_core_chk (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .mem_req(mem_req), .mem_we(mem_we), .mem_adr(mem_adr),
	.mem_ack(mem_ack), .irq_req(irq_req), .irq_taken(irq_taken), .irq_num(irq_num));
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        clock, rst, cyc, stb, we, ack, mem_req, mem_we, mem_ack, irq_taken;
	logic [5:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, q, seed;
	logic [15:0] mem_adr;
	logic [7:0]  mem_wdata, mem_rdata, irq, a, m, f;
	logic [2:0]  irq_num, last_num;
	logic [7:0]  mem [int];
	int          n_fail, checks_done, n_irq, d;
	crf_core u_crf_core (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.mem_req(mem_req), .mem_we(mem_we), .mem_adr(mem_adr), .mem_wdata(mem_wdata),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .irq_req(irq), .irq_taken(irq_taken),
		.irq_num(irq_num));
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// Memory with random stalls, irq monitor
	always @(posedge clock)
	begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack && xs() % 3 != 0)
		begin
			mem_ack <= 1'b1;
			if (mem_we)
				mem[mem_adr] = mem_wdata;
			else
				mem_rdata <= mem.exists(mem_adr) ? mem[mem_adr] : 8'h00;
		end
		if (irq_taken === 1'b1)
		begin
			n_irq++;
			last_num = irq_num;
		end
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [3:0] i, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		wdat <= d;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1)
		begin
			n_fail++;
			$display("unexpected at %0t: bus timeout", $time);
			stop_test();
		end
	endtask : wb
	task automatic rd(input logic [3:0] i, input logic [31:0] e);
		wb(1'b0, i, 32'h0000_0000);
		chk(q, e);
	endtask : rd
	task automatic idle();
		int n;
		n = 0;
		do
		begin
			wb(1'b0, crf_pkg::REG_STATUS, 32'h0000_0000);
			n++;
		end
		while (q[18:16] !== 3'h2 && n < 40);
		chk({29'h0, q[18:16]}, 32'h0000_0002);
		if (q[18:16] !== 3'h2)
			stop_test();
	endtask : idle
	task automatic op(input logic [4:0] c, input logic [15:0] g);
		wb(1'b1, crf_pkg::REG_OP, {8'h00, g, 3'h0, c});
		idle();
	endtask : op
	function automatic logic [15:0] alu(input logic [4:0] o, input logic [7:0] x, y, fl);
		logic [8:0] s;
		case (o)
			5'd1, 5'd2:
			begin
				s = {1'b0, x} + {1'b0, y} + {8'h00, o == 5'd2 && fl[0]};
				fl[4] = x[4] ^ y[4] ^ s[4];
				fl[7] = x[7] == y[7] && s[7] != x[7];
			end
			5'd3, 5'd4:
			begin
				s = {1'b0, x} - {1'b0, y} - {8'h00, o == 5'd4 && fl[0]};
				fl[7] = x[7] != y[7] && s[7] != x[7];
			end
			5'd5: s = {fl[0], x & y};
			5'd6: s = {fl[0], x | y};
			5'd7: s = {fl[0], x ^ y};
			5'd8: s = {x, 1'b0};
			5'd9: s = {x[0], 1'b0, x[7:1]};
			5'd10: s = {x, fl[0]};
			default: s = {x[0], fl[0], x[7:1]};
		endcase
		fl[0] = s[8];
		fl[2] = s[7];
		fl[1] = s[7:0] == 8'h00;
		if (o > 5'd4)
			fl[7] = o > 5'd7 ? s[7] ^ s[8] : 1'b0;
		return {fl, s[7:0]};
	endfunction : alu
	initial
	begin
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 6'h00;
		sel = 4'hF;
		wdat = 32'h0000_0000;
		irq = 8'h00;
		mem_rdata = 8'h00;
		n_fail = 0;
		checks_done = 0;
		n_irq = 0;
		seed = 32'h1795_6237;
		mem[16'hFFFE] = 8'h12;
		mem[16'hFFFF] = 8'h34;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		idle();
		rd(crf_pkg::REG_PC, 16'h1234);
		rd(crf_pkg::REG_SP, 16'h00FF);
		rd(crf_pkg::REG_FLAGS, 8'h68);
		wb(1'b1, crf_pkg::REG_FLAGS, 32'h0000_0008);
		rd(crf_pkg::REG_FLAGS, 8'h68);
		wb(1'b1, 4'hF, 32'hFFFF_FFFF);
		rd(4'hF, 32'h0000_0000);
		sel <= 4'h1;
		wb(1'b1, crf_pkg::REG_INDEX, 32'h0000_BEEF);
		rd(crf_pkg::REG_INDEX, 32'h0000_00EF);
		sel <= 4'h0;
		wb(1'b1, crf_pkg::REG_ACC, 32'h0000_0055);
		rd(crf_pkg::REG_ACC, 32'h0000_0000);
		sel <= 4'hF;
		$display("test reset done");
		f = 8'h68;
		for (int i = 0; i < 44; i++)
		begin
			a = 8'(xs());
			m = 8'(xs());
			wb(1'b1, crf_pkg::REG_ACC, {24'h00_0000, a});
			wb(1'b1, crf_pkg::REG_OPERAND, {24'h00_0000, m});
			op(5'(1 + i % 11), 16'h0000);
			{f, a} = alu(5'(1 + i % 11), a, m, f);
			rd(crf_pkg::REG_ACC, {24'h00_0000, a});
			rd(crf_pkg::REG_FLAGS, {24'h00_0000, f});
		end
		$display("test alu done");
		for (int i = 0; i < 8; i++)
		begin
			a = {4'(xs() % 10), 4'(xs() % 10)};
			m = {4'(xs() % 10), 4'(xs() % 10)};
			d = a[7:4] * 10 + a[3:0] + m[7:4] * 10 + m[3:0];
			wb(1'b1, crf_pkg::REG_ACC, {24'h00_0000, a});
			wb(1'b1, crf_pkg::REG_OPERAND, {24'h00_0000, m});
			op(5'd1, 16'h0000);
			{f, a} = alu(5'd1, a, m, f);
			op(5'd12, 16'h0000);
			a = {4'(d % 100 / 10), 4'(d % 10)};
			f[0] = d > 99;
			f[2] = a[7];
			f[1] = a == 8'h00;
			rd(crf_pkg::REG_ACC, {24'h00_0000, a});
			rd(crf_pkg::REG_FLAGS, {24'h00_0000, f});
			op(5'd14, 16'h0000);
			f[0] = m[a[2:0]];
			rd(crf_pkg::REG_FLAGS, {24'h00_0000, f});
			op(5'd13, 16'h0000);
			f[7] = 1'b0;
			f[2] = m[7];
			f[1] = m == 8'h00;
			rd(crf_pkg::REG_ACC, {24'h00_0000, m});
			rd(crf_pkg::REG_FLAGS, {24'h00_0000, f});
			a = m;
		end
		$display("test decimal done");
		wb(1'b1, crf_pkg::REG_SP, 32'h0000_1234);
		op(5'd19, 16'h0000);
		rd(crf_pkg::REG_SP, 16'h12FF);
		wb(1'b1, crf_pkg::REG_SP, 32'h0000_0080);
		op(5'd29, 16'h00A5);
		op(5'd28, 16'h003C);
		rd(crf_pkg::REG_INDEX, 16'hA53C);
		op(5'd17, 16'h0000);
		chk(mem[16'h0080], 8'hA5);
		rd(crf_pkg::REG_SP, 16'h007F);
		op(5'd29, 16'h0000);
		op(5'd18, 16'h0000);
		rd(crf_pkg::REG_INDEX, 16'hA53C);
		op(5'd15, 16'h0000);
		wb(1'b1, crf_pkg::REG_ACC, 32'h0000_0000);
		op(5'd16, 16'h0000);
		rd(crf_pkg::REG_ACC, a);
		rd(crf_pkg::REG_SP, 16'h0080);
		rd(crf_pkg::REG_FLAGS, f);
		op(5'd26, 16'h0100);
		rd(crf_pkg::REG_STATUS, 32'h0002_A63C);
		op(5'd27, 16'h0010);
		rd(crf_pkg::REG_STATUS, 32'h0002_0090);
		op(5'd22, 16'h5000);
		op(5'd23, 16'h0000);
		rd(crf_pkg::REG_PC, 16'h5001);
		$display("test stack done");
		irq <= 8'h0C;
		op(5'd24, 16'h4000);
		chk(n_irq, 0);
		op(5'd20, 16'h0000);
		f[3] = 1'b0;
		rd(crf_pkg::REG_FLAGS, f);
		op(5'd24, 16'h4000);
		chk(last_num, 3'h2);
		chk(n_irq, 1);
		f[3] = 1'b1;
		rd(crf_pkg::REG_FLAGS, f);
		rd(crf_pkg::REG_SP, 16'h007B);
		rd(crf_pkg::REG_INDEX, 16'hA53C);
		rd(crf_pkg::REG_PC, 16'h4000);
		irq <= 8'h00;
		mem[16'h007C] = 8'h01;
		mem[16'h007D] = 8'h5A;
		mem[16'h007E] = 8'h77;
		mem[16'h007F] = 8'h50;
		mem[16'h0080] = 8'h01;
		op(5'd25, 16'h0000);
		rd(crf_pkg::REG_FLAGS, 8'h61);
		rd(crf_pkg::REG_ACC, 8'h5A);
		rd(crf_pkg::REG_INDEX, 16'hA577);
		rd(crf_pkg::REG_PC, 16'h5001);
		op(5'd21, 16'h0000);
		rd(crf_pkg::REG_FLAGS, 8'h69);
		$display("test interrupt done");
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		idle();
		rd(crf_pkg::REG_FLAGS, 8'h68);
		rd(crf_pkg::REG_SP, 16'h00FF);
		$display("test second reset done");
		stop_test();
	end
endmodule : tb_top
`default_nettype wire

// ### src/crf_core.sv
// Function
// RULE_01: Eight-bit accumulator holds operands and results
// RULE_02: Index pair from high and low bytes
// RULE_03: Indexed address derives from index pair
// RULE_04: Stack pointer resets to low page top
// RULE_05: Stack reset op sets low byte ones
// RULE_06: Push decrements, pull increments stack pointer
// RULE_07: Stack offset modes use stack pointer base
// RULE_08: Counter steps on fetch, loads on jumps
// RULE_09: Reset vector loads counter, high byte first
// RULE_10: Flag bits six and five read one
// RULE_11: Overflow flag follows signed overflow
// RULE_12: Half carry from bit three into four
// RULE_13: Decimal adjust uses half carry, carry
// RULE_14: Mask blocks interrupts; set after stacking
// RULE_15: Interrupt entry never stacks index high
// RULE_16: Highest priority pending request served first
// RULE_17: Return op restores flags from stack
// RULE_18: Reset sets mask; clear op clears
// RULE_19: Negative flag copies result bit seven
// RULE_20: Zero flag set on zero result
// RULE_21: Carry from add, borrow, shifts, bit test
// RULE_22: Unaffected flags keep previous values
`timescale 1ns/100ps
`default_nettype none
module crf_core (
	// System
	input  wire logic        clock,
	input  wire logic        rst,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [5:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Memory port
	output logic             mem_req,
	output logic             mem_we,
	output logic      [15:0] mem_adr,
	output logic      [7:0]  mem_wdata,
	input  wire logic        mem_ack,
	input  wire logic [7:0]  mem_rdata,
	// Interrupt requests, bit 0 highest priority
	input  wire logic [7:0]  irq_req,
	output logic             irq_taken,
	output logic      [2:0]  irq_num
);

	logic [7:0]  acc_q;
	logic [7:0]  idx_hi_q;
	logic [7:0]  idx_lo_q;
	logic [15:0] sp_q;
	logic [15:0] pc_q;
	logic [7:0]  flags_q;
	logic [7:0]  operand_q;
	logic [15:0] eff_adr_q;
	logic [2:0]  cnt_q;
	logic        pull_h_q;
	logic [31:0] rdata_q;
	logic        ack_q;
	logic        mreq_q;
	logic        mwe_q;
	logic [15:0] madr_q;
	logic [7:0]  mwd_q;
	logic        itk_q;
	logic [2:0]  inum_q;
	crf_pkg::crf_state_t st_q;

	// Bus decode
	wire        wb_hit  = wb_cyc_i & wb_stb_i & ~ack_q;
	wire        wb_wr   = wb_hit & wb_we_i & wb_sel_i[0];
	wire [3:0]  wb_reg  = wb_adr_i[5:2];
	wire        wr_op   = wb_wr & (wb_reg == crf_pkg::REG_OP) & (st_q == crf_pkg::ST_IDLE);
	wire [4:0]  op_code = wb_dat_i[4:0];
	wire [7:0]  wbyte   = wb_dat_i[7:0];
	wire [15:0] wword   = {(wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00), wb_dat_i[7:0]};
	wire [7:0]  flags_rd = flags_q | crf_pkg::FLAGS_FIXED; // RULE_10
	wire [15:0] index_pair = {idx_hi_q, idx_lo_q}; // RULE_02

	// Arithmetic
	wire        cin      = flags_q[crf_pkg::FLAG_C];
	wire        use_c    = (op_code == crf_pkg::OP_ADC) | (op_code == crf_pkg::OP_SBC);
	wire        is_sub   = (op_code == crf_pkg::OP_SUB) | (op_code == crf_pkg::OP_SBC);
	wire [7:0]  opnd     = is_sub ? ~operand_q : operand_q;
	wire        cadd     = is_sub ? ~(use_c & cin) : (use_c & cin);
	wire [4:0]  low_sum  = {1'b0, acc_q[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cadd};
	wire [8:0]  sum      = {1'b0, acc_q} + {1'b0, opnd} + {8'h00, cadd};
	wire        ovf      = (acc_q[7] == opnd[7]) & (sum[7] != acc_q[7]);

	// Decimal adjust correction
	wire        hf       = flags_q[crf_pkg::FLAG_H];
	wire        lo_fix   = hf | (acc_q[3:0] > 4'h9);
	wire        hi_fix   = cin | (acc_q > 8'h99);
	wire [7:0]  daa_cor  = {(hi_fix ? 4'h6 : 4'h0), (lo_fix ? 4'h6 : 4'h0)}; // RULE_13
	wire [8:0]  daa_sum  = {1'b0, acc_q} + {1'b0, daa_cor};

	// Highest priority pending request, before the mask is applied
	function automatic logic [3:0] pick_irq(input logic [7:0] req);
		pick_irq = 4'h8;
		for (int i = 7; i >= 0; i--)
			if (req[i])
				pick_irq = 4'(i);
	endfunction : pick_irq

	function automatic logic [7:0] nz_flags(input logic [7:0] f, input logic [7:0] r);
		nz_flags = f;
		nz_flags[crf_pkg::FLAG_N] = r[7]; // RULE_19
		nz_flags[crf_pkg::FLAG_Z] = (r == 8'h00); // RULE_20
	endfunction : nz_flags

	wire [3:0]  irq_sel = pick_irq(irq_req); // RULE_16
	wire        irq_ok  = ~flags_q[crf_pkg::FLAG_I] & ~irq_sel[3]; // RULE_14

	// Result and flags of an operation
	logic [7:0] res;
	logic [7:0] nflags;
	logic       wr_acc;
	always_comb
	begin
		res    = acc_q;
		nflags = flags_q; // RULE_22
		wr_acc = 1'b1;
		case (crf_pkg::crf_op_t'(op_code))
			crf_pkg::OP_ADD, crf_pkg::OP_ADC:
			begin
				res = sum[7:0];
				nflags[crf_pkg::FLAG_H] = low_sum[4]; // RULE_12
				nflags[crf_pkg::FLAG_C] = sum[8]; // RULE_21
				nflags[crf_pkg::FLAG_V] = ovf; // RULE_11
			end
			crf_pkg::OP_SUB, crf_pkg::OP_SBC:
			begin
				res = sum[7:0];
				nflags[crf_pkg::FLAG_C] = ~sum[8]; // RULE_21
				nflags[crf_pkg::FLAG_V] = ovf; // RULE_11
			end
			crf_pkg::OP_AND: begin res = acc_q & operand_q; nflags[crf_pkg::FLAG_V] = 1'b0; end
			crf_pkg::OP_ORA: begin res = acc_q | operand_q; nflags[crf_pkg::FLAG_V] = 1'b0; end
			crf_pkg::OP_EOR: begin res = acc_q ^ operand_q; nflags[crf_pkg::FLAG_V] = 1'b0; end
			crf_pkg::OP_ASL, crf_pkg::OP_ROL:
			begin
				res = {acc_q[6:0], (op_code == crf_pkg::OP_ROL) & cin};
				nflags[crf_pkg::FLAG_C] = acc_q[7]; // RULE_21
				nflags[crf_pkg::FLAG_V] = acc_q[7] ^ res[7];
			end
			crf_pkg::OP_LSR, crf_pkg::OP_ROR:
			begin
				res = {(op_code == crf_pkg::OP_ROR) & cin, acc_q[7:1]};
				nflags[crf_pkg::FLAG_C] = acc_q[0]; // RULE_21
				nflags[crf_pkg::FLAG_V] = acc_q[0] ^ res[7];
			end
			crf_pkg::OP_DAA:
			begin
				res = daa_sum[7:0];
				nflags[crf_pkg::FLAG_C] = hi_fix | daa_sum[8]; // RULE_13
			end
			crf_pkg::OP_LDA: begin res = operand_q; nflags[crf_pkg::FLAG_V] = 1'b0; end
			crf_pkg::OP_TEST_BIT:
			begin
				wr_acc = 1'b0;
				nflags[crf_pkg::FLAG_C] = operand_q[acc_q[2:0]]; // RULE_21
			end
			default: wr_acc = 1'b0;
		endcase
		if (wr_acc)
			nflags = nz_flags(nflags, res);
	end

	wire alu_op = wr_op & (wr_acc | (op_code == crf_pkg::OP_TEST_BIT));

	// Memory sequencing
	wire mem_done = mreq_q & mem_ack;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			acc_q     <= 8'h00;
			idx_hi_q  <= 8'h00;
			idx_lo_q  <= 8'h00;
			sp_q      <= crf_pkg::SP_RESET; // RULE_04
			pc_q      <= 16'h0000;
			flags_q   <= crf_pkg::FLAGS_RESET; // RULE_18
			operand_q <= 8'h00;
			eff_adr_q <= 16'h0000;
			cnt_q     <= 3'h0;
			pull_h_q  <= 1'b0;
			mreq_q    <= 1'b0;
			mwe_q     <= 1'b0;
			madr_q    <= 16'h0000;
			mwd_q     <= 8'h00;
			itk_q     <= 1'b0;
			inum_q    <= 3'h0;
			st_q      <= crf_pkg::ST_BOOT_HI;
		end
		else
		begin
			itk_q <= 1'b0;
			case (st_q)
				crf_pkg::ST_BOOT_HI:
				begin
					mreq_q <= ~mem_done;
					madr_q <= mem_done ? crf_pkg::VEC_LOW_ADR : crf_pkg::VEC_HIGH_ADR;
					if (mem_done)
					begin
						pc_q[15:8] <= mem_rdata; // RULE_09
						st_q       <= crf_pkg::ST_BOOT_LO;
					end
				end
				crf_pkg::ST_BOOT_LO:
				begin
					mreq_q <= ~mem_done;
					if (mem_done)
					begin
						pc_q[7:0] <= mem_rdata; // RULE_09
						st_q      <= crf_pkg::ST_IDLE;
					end
				end
				crf_pkg::ST_MEM:
				begin
					if (mem_done)
					begin
						mreq_q <= 1'b0;
						st_q   <= crf_pkg::ST_IDLE;
						if (!mwe_q && pull_h_q)
							idx_hi_q <= mem_rdata;
						if (!mwe_q && !pull_h_q)
						begin
							acc_q   <= mem_rdata;
							flags_q <= nz_flags(flags_q, mem_rdata);
						end
					end
				end
				crf_pkg::ST_RTI:
				begin
					if (mem_done)
					begin
						case (cnt_q)
							3'h0: flags_q <= mem_rdata | crf_pkg::FLAGS_FIXED; // RULE_17
							3'h1: acc_q <= mem_rdata;
							3'h2: idx_lo_q <= mem_rdata;
							3'h3: pc_q[15:8] <= mem_rdata;
							default: pc_q[7:0] <= mem_rdata;
						endcase
						cnt_q  <= cnt_q + 3'h1;
						sp_q   <= sp_q + 16'h0001; // RULE_06
						madr_q <= sp_q + 16'h0002;
						mreq_q <= (cnt_q != crf_pkg::RTI_BYTES);
						if (cnt_q == crf_pkg::RTI_BYTES)
							st_q <= crf_pkg::ST_IDLE;
					end
				end
				crf_pkg::ST_IDLE:
				begin
					if (alu_op)
					begin
						if (wr_acc)
							acc_q <= res; // RULE_01
						flags_q <= nflags | crf_pkg::FLAGS_FIXED; // RULE_22
					end
					else if (wr_op)
					begin
						case (crf_pkg::crf_op_t'(op_code))
							crf_pkg::OP_PUSH_A, crf_pkg::OP_PUSH_H:
							begin
								mreq_q <= 1'b1;
								mwe_q  <= 1'b1;
								madr_q <= sp_q;
								mwd_q  <= (op_code == crf_pkg::OP_PUSH_H) ? idx_hi_q : acc_q;
								sp_q   <= sp_q - 16'h0001; // RULE_06
								st_q   <= crf_pkg::ST_MEM;
							end
							crf_pkg::OP_PULL_A, crf_pkg::OP_PULL_H:
							begin
								mreq_q   <= 1'b1;
								mwe_q    <= 1'b0;
								madr_q   <= sp_q + 16'h0001;
								pull_h_q <= (op_code == crf_pkg::OP_PULL_H);
								sp_q     <= sp_q + 16'h0001; // RULE_06
								st_q     <= crf_pkg::ST_MEM;
							end
							crf_pkg::OP_RSP: sp_q[7:0] <= crf_pkg::SP_LOW_TOP; // RULE_05
							crf_pkg::OP_CLI: flags_q[crf_pkg::FLAG_I] <= 1'b0; // RULE_18
							crf_pkg::OP_SEI: flags_q[crf_pkg::FLAG_I] <= 1'b1;
							crf_pkg::OP_JUMP: pc_q <= wb_dat_i[23:8]; // RULE_08
							crf_pkg::OP_FETCH: pc_q <= pc_q + 16'h0001; // RULE_08
							crf_pkg::OP_ADR_IX: eff_adr_q <= index_pair + wb_dat_i[23:8]; // RULE_03
							crf_pkg::OP_ADR_SP: eff_adr_q <= sp_q + wb_dat_i[23:8]; // RULE_07
							crf_pkg::OP_SET_X: idx_lo_q <= wb_dat_i[15:8];
							crf_pkg::OP_SET_H: idx_hi_q <= wb_dat_i[15:8];
							crf_pkg::OP_RTI:
							begin
								mreq_q <= 1'b1;
								mwe_q  <= 1'b0;
								madr_q <= sp_q + 16'h0001;
								cnt_q  <= 3'h0;
								st_q   <= crf_pkg::ST_RTI;
							end
							crf_pkg::OP_INTR:
							begin
								if (irq_ok)
								begin
									sp_q    <= sp_q - 16'h0005; // RULE_15
									flags_q[crf_pkg::FLAG_I] <= 1'b1; // RULE_14
									pc_q    <= wb_dat_i[23:8]; // RULE_08
									itk_q   <= 1'b1;
									inum_q  <= irq_sel[2:0]; // RULE_16
								end
							end
							default: ;
						endcase
					end
					else if (wb_wr)
					begin
						case (wb_reg)
							crf_pkg::REG_ACC: acc_q <= wbyte; // RULE_01
							crf_pkg::REG_INDEX: {idx_hi_q, idx_lo_q} <= wword; // RULE_02
							crf_pkg::REG_SP: sp_q <= wword;
							crf_pkg::REG_PC: pc_q <= wword;
							crf_pkg::REG_FLAGS: flags_q <= wbyte | crf_pkg::FLAGS_FIXED; // RULE_10
							crf_pkg::REG_OPERAND: operand_q <= wbyte;
							default: ;
						endcase
					end
				end
				default: st_q <= crf_pkg::ST_IDLE;
			endcase
		end
	end

	// Bus answer
	wire [31:0] rd_mux =
		(wb_reg == crf_pkg::REG_ACC)     ? {24'h00_0000, acc_q} :
		(wb_reg == crf_pkg::REG_INDEX)   ? {16'h0000, index_pair} :
		(wb_reg == crf_pkg::REG_SP)      ? {16'h0000, sp_q} :
		(wb_reg == crf_pkg::REG_PC)      ? {16'h0000, pc_q} :
		(wb_reg == crf_pkg::REG_FLAGS)   ? {24'h00_0000, flags_rd} :
		(wb_reg == crf_pkg::REG_OPERAND) ? {24'h00_0000, operand_q} :
		(wb_reg == crf_pkg::REG_STATUS)  ? {13'h0000, st_q, eff_adr_q} :
		32'h0000_0000;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q   <= wb_hit;
			rdata_q <= wb_hit ? rd_mux : 32'h0000_0000;
		end
	end

	assign wb_ack_o  = ack_q;
	assign wb_dat_o  = rdata_q;
	assign mem_req   = mreq_q;
	assign mem_we    = mwe_q;
	assign mem_adr   = madr_q;
	assign mem_wdata = mwd_q;
	assign irq_taken = itk_q;
	assign irq_num   = inum_q;

endmodule : crf_core
`default_nettype wire

// ### src/crf_pkg.sv
package crf_pkg;

	// Wishbone register indices (byte address = index * 4)
	localparam logic [3:0] REG_ACC     = 4'h0;
	localparam logic [3:0] REG_INDEX   = 4'h1;
	localparam logic [3:0] REG_SP      = 4'h2;
	localparam logic [3:0] REG_PC      = 4'h3;
	localparam logic [3:0] REG_FLAGS   = 4'h4;
	localparam logic [3:0] REG_OP      = 4'h5;
	localparam logic [3:0] REG_OPERAND = 4'h6;
	localparam logic [3:0] REG_STATUS  = 4'h7;

	// Reset values
	localparam logic [15:0] SP_RESET     = 16'h00FF;
	localparam logic [7:0]  SP_LOW_TOP   = 8'hFF;
	localparam logic [15:0] VEC_HIGH_ADR = 16'hFFFE;
	localparam logic [15:0] VEC_LOW_ADR  = 16'hFFFF;

	// Flag bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_I = 3;
	localparam int FLAG_H = 4;
	localparam int FLAG_V = 7;
	localparam logic [7:0] FLAGS_FIXED = 8'h60;
	localparam logic [7:0] FLAGS_RESET = 8'h68;

	// Operation codes written to the op register
	typedef enum logic [4:0] {
		OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_ORA, OP_EOR,
		OP_ASL, OP_LSR, OP_ROL, OP_ROR, OP_DAA, OP_LDA, OP_TEST_BIT,
		OP_PUSH_A, OP_PULL_A, OP_PUSH_H, OP_PULL_H, OP_RSP, OP_CLI, OP_SEI,
		OP_JUMP, OP_FETCH, OP_INTR, OP_RTI, OP_ADR_IX, OP_ADR_SP, OP_SET_X,
		OP_SET_H
	} crf_op_t;

	typedef enum logic [2:0] {
		ST_BOOT_HI, ST_BOOT_LO, ST_IDLE, ST_MEM, ST_RTI
	} crf_state_t;

	localparam logic [2:0] RTI_BYTES = 3'h4;

endpackage : crf_pkg
